// ### src/fsps_host.sv
/*
  Host-side controller for a flash self-programming sequencer. Software orders
  an operation over APB; the controller writes the device registers, raises
  halt to launch, waits for wake, reads the device status and reports.
  Assumes the device keeps dev_wake high from completion until halt falls,
  and holds dev_rdata stable while dev_rd is high.
*/
`timescale 1ns/1ps
module fsps_host #(
  parameter int          RD_WAIT     = 4,
  parameter logic [3:0]  MODE_RETRIES = 4'h3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dev_wr,
  output logic             dev_rd,
  output logic      [3:0]  dev_sel,
  output logic      [7:0]  dev_wdata,
  output logic             dev_halt,
  input  wire logic [7:0]  dev_rdata,
  input  wire logic        dev_wake
);

  logic                     wdt_use_reg;
  logic [3:0]               op_reg;
  logic [31:0]              args_reg;
  fsps_pkg::fsps_state_type state_reg;
  logic [3:0]               idx_reg;
  logic [3:0]               run_op_reg;
  logic                     chain_reg;
  logic [3:0]               retry_reg;
  logic [7:0]               wait_reg;
  logic [7:0]               result_reg;
  logic [7:0]               blk_reg;
  logic [7:0]               lo_reg;
  logic [7:0]               lc_reg;
  logic [7:0]               data_reg;
  logic                     done_reg;
  logic                     fail_reg;
  logic                     refused_reg;
  logic                     need_erase_reg;
  logic                     in_mode_reg;
  logic [7:0]               rdata_s;
  logic                     wake_s;
  logic                     apb_wr;
  logic                     go;
  logic                     op_legal;
  logic                     busy;
  logic                     is_mode;
  logic                     bad;
  logic                     finish;
  fsps_pkg::fsps_step_type  step;

  fsps_sync #(.WIDTH(8)) u_sync_data (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (dev_rdata),
    .q       (rdata_s)
  );

  fsps_sync #(.WIDTH(1)) u_sync_wake (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (dev_wake),
    .q       (wake_s)
  );

  // Step table: one entry per device access of each operation
  function automatic fsps_pkg::fsps_step_type get_step(
    input logic [3:0] op,
    input logic [3:0] i,
    input logic [7:0] blk,
    input logic [7:0] lo,
    input logic [7:0] lc,
    input logic [7:0] wd,
    input logic       wdt
  );
    fsps_pkg::fsps_step_type s;
    s = '{fsps_pkg::K_RD, fsps_pkg::DEV_STATUS, fsps_pkg::VAL_ZERO};
    if (op == fsps_pkg::OP_MODE_ENTER || op == fsps_pkg::OP_MODE_EXIT) begin
      case (i)
        4'h0: s = (op == fsps_pkg::OP_MODE_EXIT) ?
                  '{fsps_pkg::K_WR, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO} :
                  '{fsps_pkg::K_NOP, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO};
        4'h1: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_STATUS, fsps_pkg::VAL_ZERO};
        4'h2: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_PROT, fsps_pkg::VAL_PROT_KEY};
        4'h3, 4'h5: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_MODE,
                          (op == fsps_pkg::OP_MODE_ENTER) ? fsps_pkg::VAL_MODE_SELF
                                                          : fsps_pkg::VAL_MODE_NORM};
        4'h4: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_MODE,
                    (op == fsps_pkg::OP_MODE_ENTER) ? ~fsps_pkg::VAL_MODE_SELF
                                                    : ~fsps_pkg::VAL_MODE_NORM};
        4'h6: s = (op == fsps_pkg::OP_MODE_ENTER) ?
                  '{fsps_pkg::K_HALT, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO} :
                  '{fsps_pkg::K_NOP, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO};
        default: s = '{fsps_pkg::K_RD, fsps_pkg::DEV_STATUS, fsps_pkg::VAL_ZERO};
      endcase
    end else begin
      case (i)
        4'h0: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_CMD, {4'h0, op}};
        4'h1: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_PTR_HIGH, blk};
        4'h2: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_PTR_LOW, lo};
        4'h3: s = (op == fsps_pkg::OP_WRITE) ?
                  '{fsps_pkg::K_WR, fsps_pkg::DEV_WBUF, wd} :
                  '{fsps_pkg::K_WR, fsps_pkg::DEV_CMP_HIGH, blk};
        4'h4: s = (op == fsps_pkg::OP_WRITE) ?
                  '{fsps_pkg::K_NOP, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO} :
                  '{fsps_pkg::K_WR, fsps_pkg::DEV_CMP_LOW, lc};
        4'h5: s = '{fsps_pkg::K_WR, fsps_pkg::DEV_STATUS, fsps_pkg::VAL_ZERO};
        4'h6: s = wdt ? '{fsps_pkg::K_WR, fsps_pkg::DEV_WDT, fsps_pkg::VAL_WDT_KICK}
                      : '{fsps_pkg::K_NOP, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO};
        4'h7: s = '{fsps_pkg::K_HALT, fsps_pkg::DEV_CMD, fsps_pkg::VAL_ZERO};
        default: s = '{fsps_pkg::K_RD, fsps_pkg::DEV_STATUS, fsps_pkg::VAL_ZERO};
      endcase
    end
    return s;
  endfunction

  // Pointer values follow the operation, not software, where they are fixed
  always_comb begin
    lo_reg = fsps_pkg::VAL_ZERO;
    lc_reg = fsps_pkg::VAL_FULL;
    if (run_op_reg == fsps_pkg::OP_ERASE) begin
      lc_reg = fsps_pkg::VAL_ZERO;
    end else if (run_op_reg == fsps_pkg::OP_VERIFY2) begin
      lo_reg = args_reg[fsps_pkg::ARG_START_LSB +: 8];
      lc_reg = args_reg[fsps_pkg::ARG_END_LSB +: 8];
    end else if (run_op_reg == fsps_pkg::OP_WRITE) begin
      lo_reg = args_reg[fsps_pkg::ARG_START_LSB +: 8];
    end
  end

  assign blk_reg  = args_reg[fsps_pkg::ARG_BLOCK_LSB +: 8];
  assign data_reg = args_reg[fsps_pkg::ARG_DATA_LSB +: 8];
  assign step     = get_step(run_op_reg, idx_reg, blk_reg, lo_reg, lc_reg, data_reg,
                             wdt_use_reg);
  assign busy     = (state_reg != fsps_pkg::S_IDLE);
  assign is_mode  = (run_op_reg == fsps_pkg::OP_MODE_ENTER) ||
                    (run_op_reg == fsps_pkg::OP_MODE_EXIT);
  assign bad      = is_mode ? result_reg[fsps_pkg::DST_PROT_FAIL]
                            : (result_reg != fsps_pkg::VAL_ZERO);

  assign op_legal = (op_reg >= fsps_pkg::OP_VERIFY1) && (op_reg <= fsps_pkg::OP_ERASE_BLANK);
  assign apb_wr   = psel && penable && pwrite;
  assign go       = apb_wr && (paddr == fsps_pkg::ADDR_CTRL) && pwdata[fsps_pkg::CTRL_GO] &&
                    !busy;

  // Zero-wait APB slave; unmapped addresses answer with pslverr
  assign pready = 1'b1;

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == fsps_pkg::ADDR_CTRL) begin
      prdata[fsps_pkg::CTRL_WDT] = wdt_use_reg;
    end else if (paddr == fsps_pkg::ADDR_OP) begin
      prdata[3:0] = op_reg;
    end else if (paddr == fsps_pkg::ADDR_ARGS) begin
      prdata = args_reg;
    end else if (paddr == fsps_pkg::ADDR_STATUS) begin
      prdata[fsps_pkg::ST_BUSY]           = busy;
      prdata[fsps_pkg::ST_DONE]           = done_reg;
      prdata[fsps_pkg::ST_FAIL]           = fail_reg;
      prdata[fsps_pkg::ST_REFUSED]        = refused_reg;
      prdata[fsps_pkg::ST_NEED_ERS]       = need_erase_reg;
      prdata[fsps_pkg::ST_IN_MODE]        = in_mode_reg;
      prdata[fsps_pkg::ST_RES_LSB +: 8]   = result_reg;
    end else begin
      pslverr = psel && penable;
    end
  end

  // Software configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_use_reg <= 1'b0;
      op_reg      <= 4'h0;
      args_reg    <= 32'h0000_0000;
    end else if (apb_wr) begin
      if (paddr == fsps_pkg::ADDR_CTRL) begin
        wdt_use_reg <= pwdata[fsps_pkg::CTRL_WDT];
      end else if (paddr == fsps_pkg::ADDR_OP && !busy) begin
        op_reg <= pwdata[3:0];
      end else if (paddr == fsps_pkg::ADDR_ARGS && !busy) begin
        args_reg <= pwdata;
      end
    end
  end

  // Sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= fsps_pkg::S_IDLE;
      idx_reg    <= 4'h0;
      run_op_reg <= 4'h0;
      chain_reg  <= 1'b0;
      retry_reg  <= 4'h0;
      wait_reg   <= 8'h00;
      result_reg <= 8'h00;
    end else begin
      case (state_reg)
        fsps_pkg::S_IDLE: begin
          // Refused orders never touch the device
          if (go && op_legal &&
              !(op_reg == fsps_pkg::OP_WRITE && need_erase_reg)) begin
            chain_reg  <= (op_reg == fsps_pkg::OP_ERASE_BLANK);
            run_op_reg <= (op_reg == fsps_pkg::OP_ERASE_BLANK) ? fsps_pkg::OP_ERASE : op_reg;
            idx_reg    <= 4'h0;
            retry_reg  <= 4'h0;
            state_reg  <= fsps_pkg::S_STEP;
          end
        end
        fsps_pkg::S_STEP: begin
          if (step.kind == fsps_pkg::K_HALT) begin
            state_reg <= fsps_pkg::S_HALT;
          end else if (step.kind == fsps_pkg::K_RD) begin
            wait_reg  <= 8'h00;
            state_reg <= fsps_pkg::S_READ;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        fsps_pkg::S_HALT: begin
          // Wake from the previous launch must have dropped first
          if (!wake_s) begin
            state_reg <= fsps_pkg::S_WAKE;
          end
        end
        fsps_pkg::S_WAKE: begin
          if (wake_s) begin
            idx_reg   <= idx_reg + 4'h1;
            state_reg <= fsps_pkg::S_STEP;
          end
        end
        fsps_pkg::S_READ: begin
          if (wait_reg == 8'(RD_WAIT - 1)) begin
            result_reg <= rdata_s;
            state_reg  <= fsps_pkg::S_CHECK;
          end else begin
            wait_reg <= wait_reg + 8'h01;
          end
        end
        fsps_pkg::S_CHECK: begin
          if (is_mode && bad && retry_reg < MODE_RETRIES) begin
            retry_reg <= retry_reg + 4'h1;
            idx_reg   <= 4'h1;
            state_reg <= fsps_pkg::S_STEP;
          end else if (chain_reg && !bad) begin
            chain_reg  <= 1'b0;
            run_op_reg <= fsps_pkg::OP_BLANK;
            idx_reg    <= 4'h0;
            state_reg  <= fsps_pkg::S_STEP;
          end else begin
            state_reg <= fsps_pkg::S_IDLE;
          end
        end
        default: state_reg <= fsps_pkg::S_IDLE;
      endcase
    end
  end

  assign finish = (state_reg == fsps_pkg::S_CHECK) &&
                  !(is_mode && bad && retry_reg < MODE_RETRIES) && !(chain_reg && !bad);

  // Outcome flags for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg       <= 1'b0;
      fail_reg       <= 1'b0;
      refused_reg    <= 1'b0;
      need_erase_reg <= 1'b0;
      in_mode_reg    <= 1'b0;
    end else begin
      if (go) begin
        refused_reg <= !op_legal ||
                       (op_reg == fsps_pkg::OP_WRITE && need_erase_reg);
        done_reg    <= !op_legal || (op_reg == fsps_pkg::OP_WRITE && need_erase_reg);
        fail_reg    <= 1'b0;
      end else if (finish) begin
        done_reg <= 1'b1;
        fail_reg <= bad;
      end
      if (finish && run_op_reg == fsps_pkg::OP_WRITE && bad) begin
        need_erase_reg <= 1'b1;
      end else if (state_reg == fsps_pkg::S_CHECK && run_op_reg == fsps_pkg::OP_ERASE &&
                   !bad) begin
        need_erase_reg <= 1'b0;
      end
      if (finish && is_mode && !bad) begin
        in_mode_reg <= (run_op_reg == fsps_pkg::OP_MODE_ENTER);
      end
    end
  end

  // Device port, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_wr    <= 1'b0;
      dev_rd    <= 1'b0;
      dev_sel   <= 4'h0;
      dev_wdata <= 8'h00;
      dev_halt  <= 1'b0;
    end else begin
      dev_wr <= (state_reg == fsps_pkg::S_STEP) && (step.kind == fsps_pkg::K_WR);
      if (state_reg == fsps_pkg::S_STEP) begin
        dev_sel   <= step.sel;
        dev_wdata <= step.data;
      end
      dev_rd <= (state_reg == fsps_pkg::S_STEP && step.kind == fsps_pkg::K_RD) ||
                (state_reg == fsps_pkg::S_READ && wait_reg != 8'(RD_WAIT - 1));
      if (state_reg == fsps_pkg::S_HALT && !wake_s) begin
        dev_halt <= 1'b1;
      end else if (state_reg == fsps_pkg::S_WAKE && wake_s) begin
        dev_halt <= 1'b0;
      end
    end
  end

endmodule // fsps_host

// ### src/fsps_pkg.sv
/*
  Constants for the flash self-program sequencer controller: the APB map of the
  controller's own registers, the device register selects, command codes and
  the fixed values that firmware would otherwise write by hand.
  Assumes an 8-bit device register port and a 32-bit APB.
*/
package fsps_pkg;

  // APB map of the controller's own registers
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OP     = 8'h04;
  localparam logic [7:0] ADDR_ARGS   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // Control register fields
  localparam int CTRL_GO  = 0;
  localparam int CTRL_WDT = 1;

  // Argument register fields
  localparam int ARG_BLOCK_LSB = 0;
  localparam int ARG_START_LSB = 8;
  localparam int ARG_END_LSB   = 16;
  localparam int ARG_DATA_LSB  = 24;

  // Status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_FAIL     = 2;
  localparam int ST_REFUSED  = 3;
  localparam int ST_NEED_ERS = 4;
  localparam int ST_IN_MODE  = 5;
  localparam int ST_RES_LSB  = 8;

  // Operation codes; 1..5 equal the device command codes
  localparam logic [3:0] OP_VERIFY1     = 4'h1;
  localparam logic [3:0] OP_VERIFY2     = 4'h2;
  localparam logic [3:0] OP_ERASE       = 4'h3;
  localparam logic [3:0] OP_BLANK       = 4'h4;
  localparam logic [3:0] OP_WRITE       = 4'h5;
  localparam logic [3:0] OP_MODE_ENTER  = 4'h6;
  localparam logic [3:0] OP_MODE_EXIT   = 4'h7;
  localparam logic [3:0] OP_ERASE_BLANK = 4'h8;

  // Device register selects on the device port
  typedef enum logic [3:0] {
    DEV_CMD      = 4'h0,
    DEV_PTR_HIGH = 4'h1,
    DEV_PTR_LOW  = 4'h2,
    DEV_CMP_HIGH = 4'h3,
    DEV_CMP_LOW  = 4'h4,
    DEV_WBUF     = 4'h5,
    DEV_STATUS   = 4'h6,
    DEV_WDT      = 4'h7,
    DEV_PROT     = 4'h8,
    DEV_MODE     = 4'h9
  } fsps_dev_reg_type;

  // Fixed device values
  localparam logic [7:0] VAL_ZERO      = 8'h00;
  localparam logic [7:0] VAL_FULL      = 8'hff;
  localparam logic [7:0] VAL_WDT_KICK  = 8'hac;
  localparam logic [7:0] VAL_PROT_KEY  = 8'ha5;
  localparam logic [7:0] VAL_MODE_SELF = 8'h01;
  localparam logic [7:0] VAL_MODE_NORM = 8'h00;

  // Device status bits
  localparam int DST_PROT_FAIL   = 0;
  localparam int DST_VERIFY_FAIL = 1;
  localparam int DST_PROG_FAIL   = 2;

  // Kinds of sequence step
  typedef enum logic [1:0] {
    K_WR   = 2'b00,
    K_NOP  = 2'b01,
    K_HALT = 2'b10,
    K_RD   = 2'b11
  } fsps_kind_type;

  typedef struct packed {
    fsps_kind_type    kind;
    fsps_dev_reg_type sel;
    logic [7:0]       data;
  } fsps_step_type;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_STEP  = 3'b001,
    S_HALT  = 3'b010,
    S_WAKE  = 3'b011,
    S_READ  = 3'b100,
    S_CHECK = 3'b101
  } fsps_state_type;

endpackage

// ### src/fsps_sync.sv
/*
  Two-flop synchroniser for levels coming from the flash device.
  Assumes multi-bit inputs are held stable while they are sampled.
*/
`timescale 1ns/1ps
module fsps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // fsps_sync

// ### tb/fsps_dev_model.sv
/*
  Behavioural flash device for the fsps_host bench: status byte, wake on halt.
  Assumes the bench sets res_code and delay (at least 1) before each launch.
*/
`timescale 1ns/1ps
module fsps_dev_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  input  wire logic [3:0] dev_sel,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_halt,
  input  wire logic [7:0] res_code,
  input  wire logic [4:0] delay,
  output logic      [7:0] dev_rdata,
  output logic            dev_wake
);
  logic [7:0] status_reg;
  logic [4:0] count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 8'h00;
      count_reg  <= 5'h00;
      dev_wake   <= 1'b0;
    end else begin
      if (dev_wr && dev_sel == 4'h6) begin
        status_reg <= dev_wdata;
      end
      if (dev_halt && !dev_wake) begin
        count_reg <= count_reg + 5'h01;
      end
      // Zero is a normal end, flag bits report failure
      if (dev_halt && count_reg == delay) begin
        dev_wake   <= 1'b1;
        status_reg <= res_code;
      end
      if (!dev_halt) begin
        dev_wake  <= 1'b0;
        count_reg <= 5'h00;
      end
    end
  end

  // Off-read the bus shows the inverse, so stale data cannot pass
  assign dev_rdata = dev_rd ? status_reg : ~status_reg;
endmodule // fsps_dev_model

// ### tb/fsps_host_properties.sv
/*
  Port checker for fsps_host, bound into every instance.
  Assumes one clock pclk and reset presetn, active low.
*/
`timescale 1ns/1ps
module fsps_host_properties #(
  parameter int         RD_WAIT      = 4,
  parameter logic [3:0] MODE_RETRIES = 4'h3
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       dev_wr,
  input wire logic       dev_rd,
  input wire logic [3:0] dev_sel,
  input wire logic [7:0] dev_wdata,
  input wire logic       dev_halt,
  input wire logic       dev_wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};

  a_ready_always: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_halt_holds: assert property (dev_halt && !dev_wake |=> dev_halt)
    else $error("halt dropped early");
  a_halt_quiet: assert property (dev_halt |-> !dev_wr && !dev_rd)
    else $error("device access during halt");
  a_halt_release: assert property (dev_halt && dev_wake |-> ##[1:6] !dev_halt)
    else $error("halt not released");
  a_status_clear: assert property (dev_wr && dev_sel == 4'h6 |-> dev_wdata == 8'h00)
    else $error("status not cleared");
  a_wdt_kick: assert property (dev_wr && dev_sel == 4'h7 |-> dev_wdata == 8'hac)
    else $error("bad watchdog value");
  a_prot_key: assert property (dev_wr && dev_sel == 4'h8 |-> dev_wdata == 8'ha5)
    else $error("bad key");
  a_mode_follow: assert property (dev_wr && dev_sel == 4'h8 |=>
    (dev_wr && dev_sel == 4'h9)[*3])
    else $error("mode writes not after key");
  a_mode_invert: assert property ($past(dev_wr && dev_sel == 4'h8) && dev_wr |=>
    dev_wdata == ~$past(dev_wdata))
    else $error("mode inverse wrong");
  a_cmd_legal: assert property (dev_wr && dev_sel == 4'h0 |-> dev_wdata <= 8'h05)
    else $error("bad command code");
  a_read_hold: assert property ($rose(dev_rd) |-> dev_rd[*3])
    else $error("status read too short");
endmodule // fsps_host_properties

bind fsps_host fsps_host_properties #(
  .RD_WAIT     (RD_WAIT),
  .MODE_RETRIES(MODE_RETRIES)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .dev_wr(dev_wr),
  .dev_rd(dev_rd), .dev_sel(dev_sel), .dev_wdata(dev_wdata),
  .dev_halt(dev_halt), .dev_wake(dev_wake)
);

// ### tb/fsps_host_tb.sv
/*
  Self-checking bench for fsps_host: APB master, device model, queued notes.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
module fsps_host_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, dev_wr, dev_rd, dev_halt, dev_wake;
  logic [3:0]  dev_sel;
  logic [7:0]  dev_wdata, dev_rdata;
  logic [7:0]  res_code = 8'h00;
  logic [4:0]  delay = 5'h01;
  logic        watch = 1'b0;
  logic        arm = 1'b0;
  logic        halt_d = 1'b0;
  logic [11:0] dev_q[$];
  logic [63:0] rd_q[$];
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [31:0] q, a;
  logic        w;

  initial forever #4 pclk = ~pclk;

  fsps_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_sel(dev_sel),
    .dev_wdata(dev_wdata), .dev_halt(dev_halt), .dev_rdata(dev_rdata), .dev_wake(dev_wake));
  fsps_dev_model u_dev (.pclk(pclk), .presetn(presetn), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_sel(dev_sel), .dev_wdata(dev_wdata), .dev_halt(dev_halt), .res_code(res_code),
    .delay(delay), .dev_rdata(dev_rdata), .dev_wake(dev_wake));

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cmp_dev(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t dev %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_rd(input logic [31:0] got, input logic [63:0] me);
    total_checks++;
    if ((got & me[63:32]) !== me[31:0]) begin
      errors++;
      $display("BAD %0t read %h exp %h", $time, got, me[31:0]);
    end
  endtask

  // Device steps, halt (f00) and watched reads appear in the order noted
  always @(posedge pclk) begin
    if (dev_wr === 1'b1) cmp_dev({dev_sel, dev_wdata}, dev_q.size() ? dev_q.pop_front() : 12'hfff);
    if (dev_halt === 1'b1 && halt_d !== 1'b1)
      cmp_dev(12'hf00, dev_q.size() ? dev_q.pop_front() : 12'hfff);
    halt_d <= dev_halt;
    if (watch && psel && penable && pready && !pwrite) cmp_rd(prdata, rd_q.pop_front());
    cycles++;
    if (cycles == 60000) begin
      errors++;
      final_report;
    end
  end

  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    // Armed at setup, so a poll ending on the same edge is never taken for it
    watch   <= arm;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    watch   <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk_rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e});
    arm = 1'b1;
    apb(1'b0, ad, 32'h0);
    arm = 1'b0;
  endtask

  task note(input logic [3:0] s, input logic [7:0] d);
    dev_q.push_back({s, d});
  endtask

  task exp_op(input logic [3:0] op, input logic [31:0] g, input logic wd);
    note(4'h0, {4'h0, op});
    note(4'h1, g[7:0]);
    note(4'h2, (op == 4'h2 || op == 4'h5) ? g[15:8] : 8'h00);
    if (op == 4'h5) note(4'h5, g[31:24]);
    else note(4'h3, g[7:0]);
    if (op != 4'h5) note(4'h4, op == 4'h2 ? g[23:16] : (op == 4'h3 ? 8'h00 : 8'hff));
    note(4'h6, 8'h00);
    if (wd) note(4'h7, 8'hac);
    note(4'hf, 8'h00);
  endtask

  task go(input logic [3:0] op, input logic wd, input logic [7:0] r,
          input logic [31:0] e, input logic [31:0] m);
    int n;
    res_code <= r;
    delay    <= 5'($urandom_range(1, 20));
    apb(1'b1, 8'h04, {28'h0, op});
    apb(1'b1, 8'h08, a);
    apb(1'b1, 8'h00, {30'h0, wd, 1'b1});
    for (n = 0; n < 500; n++) begin
      apb(1'b0, 8'h0c, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk_rd(8'h0c, e, m);
    $display("test op %h done", op);
  endtask

  task mode_seq(input logic [7:0] v);
    note(4'h6, 8'h00);
    note(4'h8, 8'ha5);
    note(4'h9, v);
    note(4'h9, ~v);
    note(4'h9, v);
  endtask

  initial begin
    void'($urandom(32'h9568166d));
    a = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    mode_seq(8'h01);
    note(4'hf, 8'h00);
    go(4'h6, 1'b0, 8'h00, 32'h22, 32'hff3f);
    apb(1'b1, 8'h0c, 32'hffffffff);
    chk_rd(8'h0c, 32'h22, 32'hff3f);
    chk_rd(8'h10, 32'h0, 32'hffffffff);
    for (int op = 1; op <= 5; op++) begin
      a = $urandom;
      w = 1'($urandom);
      exp_op(4'(op), a, w);
      go(4'(op), w, 8'h00, 32'h22, 32'hff3f);
    end
    exp_op(4'h1, a, 1'b1);
    go(4'h1, 1'b1, 8'h02, 32'h226, 32'hff3f);
    exp_op(4'h5, a, 1'b0);
    go(4'h5, 1'b0, 8'h04, 32'h436, 32'hff3f);
    go(4'h5, 1'b0, 8'h00, 32'h1a, 32'h1a);
    exp_op(4'h3, a, 1'b1);
    exp_op(4'h4, a, 1'b1);
    go(4'h8, 1'b1, 8'h00, 32'h22, 32'hff3f);
    exp_op(4'h3, a, 1'b0);
    go(4'h8, 1'b0, 8'h08, 32'h826, 32'hff3f);
    for (int op = 0; op < 16; op++) begin
      if (op == 0 || op > 8) go(4'(op), 1'b0, 8'h00, 32'h0a, 32'h0a);
    end
    note(4'h0, 8'h00);
    mode_seq(8'h00);
    go(4'h7, 1'b0, 8'h00, 32'h02, 32'hff3f);
    // Key sequence keeps failing: first run plus every retry, then a failed end
    for (int k = 0; k < 4; k++) begin
      mode_seq(8'h01);
      note(4'hf, 8'h00);
    end
    go(4'h6, 1'b0, 8'h01, 32'h106, 32'hff3f);
    final_report;
  end
endmodule // fsps_host_tb
